/* rpng_pkg.sv */
`default_nettype none
package rpng_pkg;
   // register offsets on the control port
   localparam logic [15:0] ADDR_JACK_PIN_FUNCTION_CTRL = 16'h4008;
   localparam logic [15:0] ADDR_MIC_BIAS_CTRL = 16'h4010;
   localparam logic [15:0] ADDR_GAIN_CONTROL_THREE = 16'h4014;
   localparam logic [15:0] ADDR_CONVERTER_SETUP = 16'h4017;
   localparam logic [15:0] ADDR_CONVERTER_PATH_CTRL = 16'h4019;
   localparam logic [15:0] ADDR_LEFT_RECORD_VOLUME = 16'h401a;
   localparam logic [15:0] ADDR_RIGHT_RECORD_VOLUME = 16'h401b;
   localparam logic [15:0] ADDR_PROCESSOR_RUN_CTRL = 16'h40f6;

   // field positions
   localparam int PIN_FUNCTION_LSB = 4;
   localparam logic [1:0] PIN_FUNCTION_DIGMIC = 2'h2;
   localparam int MIC_SUPPLY_ENABLE_BIT = 0;
   localparam int MIC_SUPPLY_LEVEL_BIT = 2;
   localparam int MIC_SUPPLY_PERF_BIT = 3;
   localparam int GATE_TYPE_LSB = 6;
   localparam int GATE_ENABLE_BIT = 5;
   localparam int GATE_THRESHOLD_LSB = 0;
   localparam int OSR_SELECT_BIT = 3;
   localparam int SOURCE_SELECT_BIT = 2;
   localparam int HPF_ENABLE_BIT = 5;
   localparam int PROCESSOR_RUN_BIT = 0;

   // reset values
   localparam logic [7:0] RST_JACK_PIN_FUNCTION_CTRL = 8'h00;
   localparam logic [7:0] RST_MIC_BIAS_CTRL = 8'h00;
   localparam logic [7:0] RST_GAIN_CONTROL_THREE = 8'h00;
   localparam logic [7:0] RST_CONVERTER_SETUP = 8'h00;
   localparam logic [7:0] RST_CONVERTER_PATH_CTRL = 8'h20;
   localparam logic [7:0] RST_RECORD_VOLUME = 8'h00;
   localparam logic [7:0] RST_PROCESSOR_RUN_CTRL = 8'h00;

   // gate types
   localparam logic [1:0] GATE_TYPE_HOLD = 2'h0;
   localparam logic [1:0] GATE_TYPE_MUTE = 2'h1;
   localparam logic [1:0] GATE_TYPE_FADE = 2'h2;
   localparam logic [1:0] GATE_TYPE_FADE_MUTE = 2'h3;

   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int GATE_TIMEOUT_MS = 250;
   localparam int GATE_FADE_MS = 100;
   localparam int GATE_TIMEOUT_CYCLES = GATE_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int GATE_FADE_CYCLES = GATE_FADE_MS * (CLK_HZ / 1000);
   localparam int BCLK_HALF_CYCLES = 4;
   localparam int HPF_SHIFT = 12;
   localparam int OSR_LOW = 64;
   localparam int OSR_HIGH = 128;

   typedef struct packed {
      logic valid;
      logic [23:0] left;
      logic [23:0] right;
   } rpng_stereo_t;

   typedef enum {
      GATE_OPEN,
      GATE_WAIT,
      GATE_CLOSED
   } rpng_gate_state_t;
endpackage : rpng_pkg
`default_nettype wire

/* rpng_channel_proc.sv */
`default_nettype none
module rpng_channel_proc #(
   parameter int HPF_SHIFT = rpng_pkg::HPF_SHIFT
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sampleValid,
   input wire logic [23:0] sampleIn,
   input wire logic [7:0] volume,
   input wire logic hpfEnable,
   input wire logic mute,
   output logic sampleValid_r,
   output logic [23:0] sample_r
);
   logic signed [35:0] dcEst_r;
   logic signed [35:0] wideIn;
   logic signed [35:0] hpfOut;
   logic signed [23:0] filtered;
   logic signed [33:0] scaled;

   always_comb begin
      wideIn = {{12{sampleIn[23]}}, sampleIn} <<< HPF_SHIFT;
      hpfOut = (wideIn - dcEst_r) >>> HPF_SHIFT;
      filtered = hpfEnable ? hpfOut[23:0] : sampleIn;
      // one volume step removes 1/256 of the sample; 255 leaves almost nothing
      scaled = (filtered * $signed({1'b0, 9'(9'h100 - {1'b0, volume})})) >>> 8;
   end

   // leaky integrator tracks the dc level; the slow shift keeps the corner low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dcEst_r <= '0;
      end else if (sampleValid && hpfEnable) begin
         dcEst_r <= dcEst_r + ((wideIn - dcEst_r) >>> HPF_SHIFT);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sampleValid_r <= 1'b0;
         sample_r <= 24'h000000;
      end else begin
         sampleValid_r <= sampleValid;
         if (sampleValid) begin
            sample_r <= mute ? 24'h000000 : scaled[23:0];
         end
      end
   end
endmodule : rpng_channel_proc
`default_nettype wire

/* record_path_noise_gate.sv */
`default_nettype none
module record_path_noise_gate #(
   parameter int GATE_TIMEOUT_CYCLES = rpng_pkg::GATE_TIMEOUT_CYCLES,
   parameter int GATE_FADE_CYCLES = rpng_pkg::GATE_FADE_CYCLES,
   parameter int BCLK_HALF_CYCLES = rpng_pkg::BCLK_HALF_CYCLES,
   parameter int GAIN_WIDTH = 6
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire rpng_pkg::rpng_stereo_t converterIn,
   input wire logic [GAIN_WIDTH-1:0] alcGainIn,
   input wire logic detect_or_digmic_pin,
   output logic bclkOut,
   output rpng_pkg::rpng_stereo_t recordOut,
   output logic [GAIN_WIDTH-1:0] pgaGainOut,
   output logic gainHoldOut,
   output logic gateActiveOut,
   output logic jackDetectEnable,
   output logic mic_supply_output,
   output logic micSupplyHighPerf,
   output logic micSupplyLevelSel,
   output logic osr128Out
);
   localparam int TIMER_W = $clog2(GATE_TIMEOUT_CYCLES + 1);
   localparam int FADE_W = $clog2(GATE_FADE_CYCLES + 1);
   localparam int FADE_STEP = (GATE_FADE_CYCLES >> GAIN_WIDTH) > 0 ?
                              (GATE_FADE_CYCLES >> GAIN_WIDTH) : 1;
   localparam int BCLK_W = $clog2(BCLK_HALF_CYCLES + 1);
   localparam int STEP_W = $clog2(FADE_STEP + 1);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] jackPinCtrl_r;
   logic [7:0] micBiasCtrl_r;
   logic [7:0] gainControlThree_r;
   logic [7:0] converterSetup_r;
   logic [7:0] converterPathCtrl_r;
   logic [7:0] leftVolume_r;
   logic [7:0] rightVolume_r;
   logic [7:0] runCtrl_r;
   logic [7:0] regRdData_r;

   logic [1:0] pin_function_select;
   logic processor_run_bit;
   logic record_source_select;
   logic [1:0] gate_type;
   logic gate_enable;
   logic [4:0] gate_threshold;
   logic osr128;
   logic hpfEnable;
   logic digmicAllowed;

   always_comb begin
      pin_function_select = jackPinCtrl_r[rpng_pkg::PIN_FUNCTION_LSB +: 2];
      processor_run_bit = runCtrl_r[rpng_pkg::PROCESSOR_RUN_BIT];
      record_source_select = converterPathCtrl_r[rpng_pkg::SOURCE_SELECT_BIT];
      gate_type = gainControlThree_r[rpng_pkg::GATE_TYPE_LSB +: 2];
      gate_enable = gainControlThree_r[rpng_pkg::GATE_ENABLE_BIT];
      gate_threshold = gainControlThree_r[rpng_pkg::GATE_THRESHOLD_LSB +: 5];
      osr128 = converterSetup_r[rpng_pkg::OSR_SELECT_BIT];
      hpfEnable = converterPathCtrl_r[rpng_pkg::HPF_ENABLE_BIT];
      digmicAllowed = (pin_function_select == rpng_pkg::PIN_FUNCTION_DIGMIC) &&
                      processor_run_bit;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         jackPinCtrl_r <= rpng_pkg::RST_JACK_PIN_FUNCTION_CTRL;
         micBiasCtrl_r <= rpng_pkg::RST_MIC_BIAS_CTRL;
         gainControlThree_r <= rpng_pkg::RST_GAIN_CONTROL_THREE;
         converterSetup_r <= rpng_pkg::RST_CONVERTER_SETUP;
         converterPathCtrl_r <= rpng_pkg::RST_CONVERTER_PATH_CTRL;
         leftVolume_r <= rpng_pkg::RST_RECORD_VOLUME;
         rightVolume_r <= rpng_pkg::RST_RECORD_VOLUME;
         runCtrl_r <= rpng_pkg::RST_PROCESSOR_RUN_CTRL;
      end else if (regWrite) begin
         unique case (regAddr)
            rpng_pkg::ADDR_JACK_PIN_FUNCTION_CTRL: jackPinCtrl_r <= regWrData;
            rpng_pkg::ADDR_MIC_BIAS_CTRL: micBiasCtrl_r <= regWrData;
            rpng_pkg::ADDR_GAIN_CONTROL_THREE: gainControlThree_r <= regWrData;
            rpng_pkg::ADDR_CONVERTER_SETUP: converterSetup_r <= regWrData;
            rpng_pkg::ADDR_CONVERTER_PATH_CTRL: converterPathCtrl_r <= regWrData;
            rpng_pkg::ADDR_LEFT_RECORD_VOLUME: leftVolume_r <= regWrData;
            rpng_pkg::ADDR_RIGHT_RECORD_VOLUME: rightVolume_r <= regWrData;
            rpng_pkg::ADDR_PROCESSOR_RUN_CTRL: runCtrl_r <= regWrData;
            default: begin
            end
         endcase
      end
   end

   // read data is captured one edge after the read strobe; unmapped reads give zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         regRdData_r <= 8'h00;
      end else if (regRead) begin
         unique case (regAddr)
            rpng_pkg::ADDR_JACK_PIN_FUNCTION_CTRL: regRdData_r <= jackPinCtrl_r;
            rpng_pkg::ADDR_MIC_BIAS_CTRL: regRdData_r <= micBiasCtrl_r;
            rpng_pkg::ADDR_GAIN_CONTROL_THREE: regRdData_r <= gainControlThree_r;
            rpng_pkg::ADDR_CONVERTER_SETUP: regRdData_r <= converterSetup_r;
            rpng_pkg::ADDR_CONVERTER_PATH_CTRL: regRdData_r <= converterPathCtrl_r;
            rpng_pkg::ADDR_LEFT_RECORD_VOLUME: regRdData_r <= leftVolume_r;
            rpng_pkg::ADDR_RIGHT_RECORD_VOLUME: regRdData_r <= rightVolume_r;
            rpng_pkg::ADDR_PROCESSOR_RUN_CTRL: regRdData_r <= runCtrl_r;
            default: regRdData_r <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // static control outputs
   logic jackDetectEnable_r;
   logic micSupplyEnable_r;
   logic micSupplyHighPerf_r;
   logic micSupplyLevelSel_r;
   logic osr128_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         jackDetectEnable_r <= 1'b0;
         micSupplyEnable_r <= 1'b0;
         micSupplyHighPerf_r <= 1'b0;
         micSupplyLevelSel_r <= 1'b0;
         osr128_r <= 1'b0;
      end else begin
         jackDetectEnable_r <= pin_function_select != rpng_pkg::PIN_FUNCTION_DIGMIC;
         micSupplyEnable_r <= micBiasCtrl_r[rpng_pkg::MIC_SUPPLY_ENABLE_BIT];
         micSupplyHighPerf_r <= micBiasCtrl_r[rpng_pkg::MIC_SUPPLY_PERF_BIT];
         micSupplyLevelSel_r <= micBiasCtrl_r[rpng_pkg::MIC_SUPPLY_LEVEL_BIT];
         osr128_r <= osr128;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit clock and microphone decimation
   logic [BCLK_W-1:0] bclkCnt_r;
   logic bclk_r;
   logic bclkRise;
   logic pinMeta_r;
   logic pinSync_r;
   logic [7:0] onesCnt_r;
   logic [7:0] bitCnt_r;
   logic digmicValid_r;
   logic [23:0] digmicSample_r;
   logic [7:0] osrBits;
   logic [7:0] onesNext;
   logic signed [23:0] centered;

   // bit clock runs only while the microphone may be used, so it is quiet otherwise
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bclkCnt_r <= '0;
         bclk_r <= 1'b0;
      end else if (!digmicAllowed) begin
         bclkCnt_r <= '0;
         bclk_r <= 1'b0;
      end else if (bclkCnt_r == BCLK_W'(BCLK_HALF_CYCLES - 1)) begin
         bclkCnt_r <= '0;
         bclk_r <= ~bclk_r;
      end else begin
         bclkCnt_r <= bclkCnt_r + 1'b1;
      end
   end

   assign bclkRise = digmicAllowed && !bclk_r &&
                     (bclkCnt_r == BCLK_W'(BCLK_HALF_CYCLES - 1));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pinMeta_r <= 1'b0;
         pinSync_r <= 1'b0;
      end else begin
         pinMeta_r <= detect_or_digmic_pin;
         pinSync_r <= pinMeta_r;
      end
   end

   always_comb begin
      osrBits = osr128 ? 8'(rpng_pkg::OSR_HIGH) : 8'(rpng_pkg::OSR_LOW);
      onesNext = onesCnt_r + {7'h00, pinSync_r};
      centered = 24'($signed({1'b0, onesNext}) - $signed({1'b0, osrBits >> 1}));
   end

   // ones density over one oversampling window becomes one pcm sample
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         onesCnt_r <= 8'h00;
         bitCnt_r <= 8'h00;
         digmicValid_r <= 1'b0;
         digmicSample_r <= 24'h000000;
      end else begin
         digmicValid_r <= 1'b0;
         if (!digmicAllowed) begin
            onesCnt_r <= 8'h00;
            bitCnt_r <= 8'h00;
         end else if (bclkRise) begin
            if (bitCnt_r >= osrBits - 8'h01) begin
               onesCnt_r <= 8'h00;
               bitCnt_r <= 8'h00;
               digmicValid_r <= 1'b1;
               if (onesNext == osrBits) begin
                  digmicSample_r <= 24'h7fffff;
               end else begin
                  digmicSample_r <= osr128 ? centered <<< 16 : centered <<< 17;
               end
            end else begin
               onesCnt_r <= onesNext;
               bitCnt_r <= bitCnt_r + 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared decimator input: exactly one source reaches the channels
   logic srcValid;
   logic [23:0] srcLeft;
   logic [23:0] srcRight;

   always_comb begin
      if (record_source_select) begin
         srcValid = digmicValid_r;
         srcLeft = digmicSample_r;
         srcRight = digmicSample_r;
      end else begin
         srcValid = converterIn.valid;
         srcLeft = converterIn.left;
         srcRight = converterIn.right;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // noise gate
   rpng_pkg::rpng_gate_state_t gateState_r;
   logic [TIMER_W-1:0] timer_r;
   logic [FADE_W-1:0] fadeCnt_r;
   logic [STEP_W-1:0] stepCnt_r;
   logic fadeDone_r;
   logic [GAIN_WIDTH-1:0] pgaGain_r;
   logic gainHold_r;
   logic gateActive_r;
   logic [23:0] magLeft;
   logic [23:0] magRight;
   logic [23:0] level;
   logic [24:0] enterLevel;
   logic [24:0] exitLevel;
   logic [4:0] shiftAmt;
   logic muteNow;

   always_comb begin
      magLeft = srcLeft[23] ? 24'(-srcLeft) : srcLeft;
      magRight = srcRight[23] ? 24'(-srcRight) : srcRight;
      level = (magLeft > magRight) ? magLeft : magRight;
      shiftAmt = (gate_threshold > 5'h16) ? 5'h16 : gate_threshold;
      enterLevel = 25'h0000001 << shiftAmt;
      exitLevel = enterLevel << 1;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gateState_r <= rpng_pkg::GATE_OPEN;
         timer_r <= '0;
      end else if (!gate_enable) begin
         gateState_r <= rpng_pkg::GATE_OPEN;
         timer_r <= '0;
      end else begin
         unique case (gateState_r)
            rpng_pkg::GATE_OPEN: begin
               timer_r <= '0;
               if (srcValid && ({1'b0, level} < enterLevel)) begin
                  gateState_r <= rpng_pkg::GATE_WAIT;
               end
            end
            rpng_pkg::GATE_WAIT: begin
               if (srcValid && ({1'b0, level} >= enterLevel)) begin
                  gateState_r <= rpng_pkg::GATE_OPEN;
                  timer_r <= '0;
               end else if (timer_r == TIMER_W'(GATE_TIMEOUT_CYCLES - 1)) begin
                  gateState_r <= rpng_pkg::GATE_CLOSED;
               end else begin
                  timer_r <= timer_r + 1'b1;
               end
            end
            rpng_pkg::GATE_CLOSED: begin
               if (srcValid && ({1'b0, level} >= exitLevel)) begin
                  gateState_r <= rpng_pkg::GATE_OPEN;
                  timer_r <= '0;
               end
            end
         endcase
      end
   end

   // the fade walks the gain down one code per step across the fade interval
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fadeCnt_r <= '0;
         stepCnt_r <= '0;
         fadeDone_r <= 1'b0;
         pgaGain_r <= '0;
         gainHold_r <= 1'b0;
      end else if (gateState_r != rpng_pkg::GATE_CLOSED) begin
         fadeCnt_r <= '0;
         stepCnt_r <= '0;
         fadeDone_r <= 1'b0;
         pgaGain_r <= alcGainIn;
         gainHold_r <= 1'b0;
      end else begin
         unique case (gate_type)
            rpng_pkg::GATE_TYPE_HOLD: gainHold_r <= 1'b1;
            rpng_pkg::GATE_TYPE_MUTE: begin
               gainHold_r <= 1'b0;
               pgaGain_r <= alcGainIn;
            end
            rpng_pkg::GATE_TYPE_FADE, rpng_pkg::GATE_TYPE_FADE_MUTE: begin
               gainHold_r <= 1'b1;
               if (fadeCnt_r == FADE_W'(GATE_FADE_CYCLES - 1)) begin
                  fadeDone_r <= 1'b1;
               end else begin
                  fadeCnt_r <= fadeCnt_r + 1'b1;
               end
               if (stepCnt_r == STEP_W'(FADE_STEP - 1)) begin
                  stepCnt_r <= '0;
                  if (pgaGain_r != '0) begin
                     pgaGain_r <= pgaGain_r - 1'b1;
                  end
               end else begin
                  stepCnt_r <= stepCnt_r + 1'b1;
               end
            end
         endcase
      end
   end

   always_comb begin
      muteNow = (gateState_r == rpng_pkg::GATE_CLOSED) &&
                ((gate_type == rpng_pkg::GATE_TYPE_MUTE) ||
                 ((gate_type == rpng_pkg::GATE_TYPE_FADE_MUTE) && fadeDone_r));
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gateActive_r <= 1'b0;
      end else begin
         gateActive_r <= gateState_r == rpng_pkg::GATE_CLOSED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-channel volume, dc removal and mute
   logic leftValid_r;
   logic [23:0] leftSample_r;
   logic [23:0] rightSample_r;

   rpng_channel_proc u_left (
      .ref_clk(ref_clk),
      .rst(rst),
      .sampleValid(srcValid),
      .sampleIn(srcLeft),
      .volume(leftVolume_r),
      .hpfEnable(hpfEnable),
      .mute(muteNow),
      .sampleValid_r(leftValid_r),
      .sample_r(leftSample_r)
   );

   rpng_channel_proc u_right (
      .ref_clk(ref_clk),
      .rst(rst),
      .sampleValid(srcValid),
      .sampleIn(srcRight),
      .volume(rightVolume_r),
      .hpfEnable(hpfEnable),
      .mute(muteNow),
      .sampleValid_r(),
      .sample_r(rightSample_r)
   );

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign regRdData = regRdData_r;
   assign bclkOut = bclk_r;
   assign recordOut.valid = leftValid_r;
   assign recordOut.left = leftSample_r;
   assign recordOut.right = rightSample_r;
   assign pgaGainOut = pgaGain_r;
   assign gainHoldOut = gainHold_r;
   assign gateActiveOut = gateActive_r;
   assign jackDetectEnable = jackDetectEnable_r;
   assign mic_supply_output = micSupplyEnable_r;
   assign micSupplyHighPerf = micSupplyHighPerf_r;
   assign micSupplyLevelSel = micSupplyLevelSel_r;
   assign osr128Out = osr128_r;
endmodule : record_path_noise_gate
`default_nettype wire

/* rpng_checker.sv */
`default_nettype none
module rpng_checker #(
   parameter int GAIN_WIDTH = 6
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic [GAIN_WIDTH-1:0] alcGainIn,
   input wire logic bclkOut,
   input wire rpng_pkg::rpng_stereo_t recordOut,
   input wire logic [GAIN_WIDTH-1:0] pgaGainOut,
   input wire logic gainHoldOut,
   input wire logic gateActiveOut,
   input wire logic jackDetectEnable,
   input wire logic mic_supply_output,
   input wire logic osr128Out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [1:0] gType_r;
   // snooped type field, so mode checks need no probe inside the block
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) gType_r <= 2'h0;
      else if (regWrite && regAddr == 16'h4014) gType_r <= regWrData[7:6];
   end
   a_jack_detect_off: assert property (
      regWrite && regAddr == 16'h4008 && regWrData[5:4] == 2'h2 |-> ##2 !jackDetectEnable)
      else $error("detect stays on");
   a_bclk_idle: assert property (jackDetectEnable [*3] |-> !bclkOut)
      else $error("bit clock runs");
   a_bclk_period: assert property (
      $rose(bclkOut) |-> ##1 (!$rose(bclkOut)) [*7]) else $error("bit clock fast");
   a_osr_select: assert property (
      regWrite && regAddr == 16'h4017 |-> ##2 osr128Out == $past(regWrData[3], 2))
      else $error("ratio wrong");
   a_bias_enable: assert property (
      regWrite && regAddr == 16'h4010 |-> ##2 mic_supply_output == $past(regWrData[0], 2))
      else $error("bias wrong");
   a_hold_gain: assert property (
      gType_r == 2'h0 && gainHoldOut && $past(gainHoldOut) |-> $stable(pgaGainOut))
      else $error("gain moved");
   a_fade_step: assert property (
      gType_r[1] && gainHoldOut && $past(gainHoldOut) |-> pgaGainOut == $past(pgaGainOut)
      || pgaGainOut == $past(pgaGainOut) - 1'b1) else $error("fade step");
   a_gain_follow: assert property (
      !$past(rst) && !gainHoldOut && !$past(gainHoldOut) |-> pgaGainOut == $past(alcGainIn))
      else $error("gain not tracking");
   a_mute_zero: assert property (
      gType_r == 2'h1 && recordOut.valid && gateActiveOut && $past(gateActiveOut, 3)
      |-> recordOut.left == 24'h0 && recordOut.right == 24'h0) else $error("not muted");
   c_gate_close: cover property ($rose(gateActiveOut));
   c_bclk_run: cover property ($rose(bclkOut));
   c_fade_end: cover property (gainHoldOut && pgaGainOut == '0);
endmodule : rpng_checker
`default_nettype wire

/* rpng_mic_model.sv */
`default_nettype none
module rpng_mic_model (
   input wire logic bclk,
   input wire logic allOnes,
   output logic micData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic bitPhase = 1'b0;
   initial micData = 1'b0;
   // bit is valid from 25 ns after the fall, ready before the next rise
   always @(negedge bclk) begin
      bitPhase = ~bitPhase;
      micData <= #25 allOnes | bitPhase;
   end
   // after the rise the line floats: never leave the old bit showing
   always @(posedge bclk) micData <= #12 ~micData;
endmodule : rpng_mic_model
`default_nettype wire

/* record_path_noise_gate_test.sv */
`default_nettype none
module record_path_noise_gate_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [15:0] a; logic [7:0] rv; logic [7:0] wv; logic [7:0] xv;} rpng_row_t;
   logic ref_clk, rst, regWrite, regRead, bclkOut, gainHoldOut, gateActiveOut, micPin, allOnes;
   logic jackDetectEnable, mic_supply_output, micSupplyHighPerf, micSupplyLevelSel, osr128Out;
   logic [15:0] regAddr;
   logic [7:0] regWrData, regRdData;
   logic [5:0] alcGainIn, pgaGainOut;
   rpng_pkg::rpng_stereo_t converterIn, recordOut;
   int nMismatch, totalChecks, cycles, gap, t;
   logic seen;
   rpng_row_t rows [9] = '{'{16'h4008, 8'h00, 8'h20, 8'h20}, '{16'h4010, 8'h00, 8'h0d, 8'h0d},
      '{16'h4014, 8'h00, 8'h15, 8'h15}, '{16'h4017, 8'h00, 8'h08, 8'h08},
      '{16'h4019, 8'h20, 8'h04, 8'h04}, '{16'h401a, 8'h00, 8'h00, 8'h00},
      '{16'h401b, 8'h00, 8'h80, 8'h80}, '{16'h40f6, 8'h00, 8'h01, 8'h01},
      '{16'h4000, 8'h00, 8'h5a, 8'h00}};
   logic [23:0] expQ [4] = '{24'h100, 24'h0, 24'h100, 24'h0};
   logic [5:0] expG [4] = '{6'h20, 6'h30, 6'h00, 6'h00};
   record_path_noise_gate #(.GATE_TIMEOUT_CYCLES(200), .GATE_FADE_CYCLES(128))
      record_path_noise_gate_inst (.ref_clk, .rst, .regAddr, .regWrData, .regWrite, .regRead,
      .regRdData, .converterIn, .alcGainIn, .detect_or_digmic_pin(micPin), .bclkOut, .recordOut,
      .pgaGainOut, .gainHoldOut, .gateActiveOut, .jackDetectEnable, .mic_supply_output,
      .micSupplyHighPerf, .micSupplyLevelSel, .osr128Out);
   rpng_mic_model rpng_mic_model_inst (.bclk(bclkOut), .allOnes, .micData(micPin));
   ////////////////////////////////////////
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 chk(regRdData, e);
   endtask : rd
   task automatic send(input logic [23:0] v);
      @(posedge ref_clk);
      converterIn <= {1'b1, v, v};
      @(posedge ref_clk);
      converterIn.valid <= 1'b0;
      #1 chk(recordOut.valid, 1'b1);
   endtask : send
   // counts falling edges so the count never races the output update
   task automatic nextSample(output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (recordOut.valid !== 1'b1 && n < 3000);
   endtask : nextSample
   task wrap_up;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         nMismatch++;
         wrap_up();
      end
   end
   initial begin
      {rst, regWrite, regRead, regAddr, regWrData, converterIn} = '0;
      rst = 1'b1;
      alcGainIn = 6'h20;
      allOnes = 1'b1;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].wv);
         rd(rows[i].a, rows[i].xv);
      end
      chk(jackDetectEnable, 1'b0);
      chk({mic_supply_output, micSupplyHighPerf, micSupplyLevelSel}, 3'h7);
      $display("test registers done");
      nextSample(gap);
      nextSample(gap);
      chk(gap, 1024);
      chk(recordOut.left, 24'h7fffff);
      chk(recordOut.right, 24'h3fffff);
      wr(16'h4017, 8'h00);
      nextSample(gap);
      nextSample(gap);
      chk(gap, 512);
      allOnes <= 1'b0;
      repeat (2) nextSample(gap);
      chk(recordOut.left, 24'h0);
      wr(16'h40f6, 8'h00);
      repeat (40) @(negedge ref_clk);
      seen = 1'b0;
      repeat (600) @(negedge ref_clk) seen = seen | bclkOut | recordOut.valid;
      chk(seen, 1'b0);
      $display("test microphone done");
      wr(16'h4019, 8'h00);
      wr(16'h401b, 8'h00);
      for (t = 0; t < 4; t++) begin
         wr(16'h4014, {t[1:0], 6'h2a});
         send(24'h1000);
         send(24'h100);
         repeat (150) @(negedge ref_clk);
         send(24'h600);
         send(24'h100);
         repeat (150) @(negedge ref_clk);
         chk(gateActiveOut, 1'b0);
         repeat (60) @(negedge ref_clk);
         chk(gateActiveOut, 1'b1);
         @(posedge ref_clk) alcGainIn <= 6'h30;
         repeat (140) @(negedge ref_clk);
         send(24'h100);
         chk(recordOut.left, expQ[t]);
         chk(pgaGainOut, expG[t]);
         chk(gainHoldOut, t != 1);
         send(24'h600);
         chk(gateActiveOut, 1'b1);
         send(24'h800);
         send(24'h800);
         chk(recordOut.left, 24'h800);
         @(negedge ref_clk);
         chk({gateActiveOut, pgaGainOut}, 7'h30);
         @(posedge ref_clk) alcGainIn <= 6'h20;
      end
      $display("test gate done");
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i]) rd(rows[i].a, rows[i].rv);
      chk({jackDetectEnable, bclkOut}, 2'h2);
      // high-pass is on after reset: a steady level starts to be pulled toward zero
      send(24'h1000);
      send(24'h1000);
      chk(recordOut.left, 24'h000fff);
      $display("test reset done");
      wrap_up();
   end
endmodule : record_path_noise_gate_test
bind record_path_noise_gate rpng_checker #(.GAIN_WIDTH(GAIN_WIDTH)) rpng_checker_inst (.ref_clk,
   .rst, .regAddr, .regWrData, .regWrite, .alcGainIn, .bclkOut, .recordOut, .pgaGainOut,
   .gainHoldOut, .gateActiveOut, .jackDetectEnable, .mic_supply_output, .osr128Out);
`default_nettype wire
